// ---- insr_readout.sv ----
// result snapshot readout with its register port
`timescale 1ns/1ps
module insr_readout #(
  parameter int COUNT_WIDTH = 24,
  parameter int PROX_WIDTH = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [7:0] regAddr,
  input wire logic regReadStart,
  input wire logic regWrite,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData,
  input wire logic oscPin,
  input wire logic [PROX_WIDTH-1:0] impedanceRaw,
  input wire logic impedanceBelowFloor,
  input wire logic impedanceAboveCeiling,
  output logic [7:0] impedanceRangeFloor,
  output logic [7:0] impedanceRangeCeiling,
  output logic conversionActive
);
  logic [2:0] windowCode;
  logic convDone;
  logic [COUNT_WIDTH-1:0] convCount;
  logic [PROX_WIDTH-1:0] latestProx;
  logic [COUNT_WIDTH-1:0] latestCount;
  logic [PROX_WIDTH-1:0] proxSnap;
  logic [COUNT_WIDTH-1:0] countSnap;
  logic newData;

  insr_rate_counter #(
    .COUNT_WIDTH(COUNT_WIDTH)
  ) u_rate (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ce(ce),
    .oscPin(oscPin),
    .enable(conversionActive),
    .windowCode(windowCode),
    .done(convDone),
    .periodCount(convCount)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  wire readLow = ce && regReadStart && hit(regAddr, insr_pkg::ADDR_PROX_LOW);
  wire writeOk = ce && regWrite;
  // clip to the ends of the code range instead of wrapping
  wire [PROX_WIDTH-1:0] clippedProx =
    impedanceAboveCeiling ? {PROX_WIDTH{1'b1}} :
    impedanceBelowFloor ? {PROX_WIDTH{1'b0}} : impedanceRaw;
  // snapshot source is what the read itself will return
  wire [PROX_WIDTH-1:0] next_proxSnap =
    readLow ? latestProx : proxSnap;
  wire [COUNT_WIDTH-1:0] next_countSnap =
    readLow ? latestCount : countSnap;
  // the read that takes the snapshot already returns its low byte
  wire [7:0] freshLowByte = next_proxSnap[7:0];
  wire [7:0] statusByte = (8'h01 << insr_pkg::STATUS_WAKE_OFF_BIT) |
    ({7'h00, ~newData} << insr_pkg::STATUS_NO_DATA_BIT);

  logic [7:0] next_readData;
  always_comb
  begin
    unique case (regAddr)
      insr_pkg::ADDR_RANGE_CEILING: next_readData = impedanceRangeCeiling;
      insr_pkg::ADDR_RANGE_FLOOR: next_readData = impedanceRangeFloor;
      insr_pkg::ADDR_CONFIG: next_readData = {5'h00, windowCode};
      insr_pkg::ADDR_POWER: next_readData = {7'h00, conversionActive};
      insr_pkg::ADDR_STATUS: next_readData = statusByte;
      insr_pkg::ADDR_PROX_LOW: next_readData = freshLowByte;
      insr_pkg::ADDR_PROX_HIGH: next_readData = proxSnap[15:8];
      insr_pkg::ADDR_COUNT_LOW: next_readData = countSnap[7:0];
      insr_pkg::ADDR_COUNT_MID: next_readData = countSnap[15:8];
      insr_pkg::ADDR_COUNT_HIGH: next_readData = countSnap[23:16];
      default: next_readData = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      impedanceRangeCeiling <= insr_pkg::RESET_RANGE_CEILING;
      impedanceRangeFloor <= insr_pkg::RESET_RANGE_FLOOR;
      windowCode <= insr_pkg::RESET_WINDOW_CODE;
      conversionActive <= 1'b0;
    end
    else if (writeOk)
    begin
      // codes are stored as written; unlisted codes are the host's problem
      if (hit(regAddr, insr_pkg::ADDR_RANGE_CEILING))
        impedanceRangeCeiling <= regWriteData;
      if (hit(regAddr, insr_pkg::ADDR_RANGE_FLOOR))
        impedanceRangeFloor <= regWriteData;
      if (hit(regAddr, insr_pkg::ADDR_CONFIG))
        windowCode <= regWriteData[insr_pkg::WINDOW_CODE_LSB +: 3];
      if (hit(regAddr, insr_pkg::ADDR_POWER))
        conversionActive <= regWriteData[insr_pkg::POWER_ACTIVE_BIT];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      latestProx <= '0;
      latestCount <= '0;
      proxSnap <= '0;
      countSnap <= '0;
      newData <= 1'b0;
      regReadData <= 8'h00;
    end
    else if (ce)
    begin
      if (convDone)
      begin
        latestProx <= clippedProx;
        latestCount <= convCount;
      end
      proxSnap <= next_proxSnap;
      countSnap <= next_countSnap;
      // a conversion landing on the snapshot read stays pending
      newData <= convDone | (newData & ~readLow);
      if (regReadStart)
        regReadData <= next_readData;
    end
  end

  sequence s_read_low;
    regReadStart && ce && regAddr == insr_pkg::ADDR_PROX_LOW;
  endsequence

  sequence s_read_at(logic [7:0] a);
    regReadStart && ce && regAddr == a;
  endsequence

  property p_snapshot_load;
    @(posedge clk_sys) disable iff (!reset_n)
    s_read_low |=> proxSnap == $past(latestProx)
      && countSnap == $past(latestCount);
  endproperty
  a_snapshot_load: assert property (p_snapshot_load)
    else $error("snapshot not loaded by low proximity read");

  property p_snapshot_hold;
    @(posedge clk_sys) disable iff (!reset_n)
    !(regReadStart && ce && regAddr == insr_pkg::ADDR_PROX_LOW)
      |=> $stable(proxSnap) && $stable(countSnap);
  endproperty
  a_snapshot_hold: assert property (p_snapshot_hold)
    else $error("result registers changed without a snapshot read");

  property p_atomic_low;
    @(posedge clk_sys) disable iff (!reset_n)
    s_read_low |=> regReadData == proxSnap[7:0]
      && proxSnap == $past(latestProx);
  endproperty
  a_atomic_low: assert property (p_atomic_low)
    else $error("low proximity byte not from the new snapshot");

  property p_count_mid;
    @(posedge clk_sys) disable iff (!reset_n)
    s_read_at(insr_pkg::ADDR_COUNT_MID) |=> regReadData == countSnap[15:8];
  endproperty
  a_count_mid: assert property (p_count_mid)
    else $error("count middle byte read wrong");

  property p_count_high;
    @(posedge clk_sys) disable iff (!reset_n)
    s_read_at(insr_pkg::ADDR_COUNT_HIGH) |=>
      regReadData == countSnap[23:16];
  endproperty
  a_count_high: assert property (p_count_high)
    else $error("count high byte read wrong");

  property p_count_low;
    @(posedge clk_sys) disable iff (!reset_n)
    s_read_at(insr_pkg::ADDR_COUNT_LOW) |=> regReadData == countSnap[7:0];
  endproperty
  a_count_low: assert property (p_count_low)
    else $error("count low byte read wrong");

  property p_clip_high;
    @(posedge clk_sys) disable iff (!reset_n)
    ce && convDone && impedanceAboveCeiling |=> &latestProx;
  endproperty
  a_clip_high: assert property (p_clip_high)
    else $error("impedance above ceiling not clipped");

  property p_floor_reset;
    @(posedge clk_sys)
    !$past(reset_n) && reset_n |-> impedanceRangeFloor ==
      insr_pkg::RESET_RANGE_FLOOR;
  endproperty
  a_floor_reset: assert property (p_floor_reset)
    else $error("floor setting did not reset to its default");

  property p_clip_low;
    @(posedge clk_sys) disable iff (!reset_n)
    ce && convDone && impedanceBelowFloor && !impedanceAboveCeiling
      |=> latestProx == '0;
  endproperty
  a_clip_low: assert property (p_clip_low)
    else $error("impedance below floor not clipped");

  // read data must stand until the next read start
  property p_read_hold;
    @(posedge clk_sys) disable iff (!reset_n)
    !(ce && regReadStart) |=> $stable(regReadData);
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read data changed without a read start");

  property p_pending_set;
    @(posedge clk_sys) disable iff (!reset_n)
    ce && convDone |=> newData;
  endproperty
  a_pending_set: assert property (p_pending_set)
    else $error("finished conversion not flagged as pending");

  property p_freeze;
    @(posedge clk_sys) disable iff (!reset_n)
    !ce |=> $stable(latestProx) && $stable(proxSnap) && $stable(countSnap);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("result registers moved with clock enable low");
endmodule

// ---- insr_pkg.sv ----
// constants and register map of the inductive result snapshot readout
// What this block does
// - Frequency count bits 15:8 read-only at 0x24.
// - Frequency count bits 23:16 read-only at 0x25, most significant byte.
// - Results copied into result registers only when a 0x21 read starts.
// - Without a 0x21 read, result registers hold across later conversions.
// - Impedance result clipped when outside floor and ceiling range.
// - Impedance floor resets to 0x14; host replaces it before conversion.
// - Output rate is oscillation frequency over one third of window setting.
// - Count bits 7:0 at 0x23 and proximity bits 7:0 at 0x21, read-only.
package insr_pkg;
  localparam logic [7:0] ADDR_RANGE_CEILING = 8'h01;
  localparam logic [7:0] ADDR_RANGE_FLOOR = 8'h02;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_POWER = 8'h0B;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_PROX_LOW = 8'h21;
  localparam logic [7:0] ADDR_PROX_HIGH = 8'h22;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h23;
  localparam logic [7:0] ADDR_COUNT_MID = 8'h24;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h25;
  localparam logic [7:0] RESET_RANGE_CEILING = 8'h00;
  localparam logic [7:0] RESET_RANGE_FLOOR = 8'h14;
  localparam logic [2:0] RESET_WINDOW_CODE = 3'h0;
  localparam int WINDOW_CODE_LSB = 0;
  localparam int POWER_ACTIVE_BIT = 0;
  localparam int STATUS_NO_DATA_BIT = 6;
  localparam int STATUS_WAKE_OFF_BIT = 5;
  // shortest conversion window is 192 oscillations; one third of that
  localparam int BASE_WINDOW = 192;
  localparam int WINDOW_DIVISOR = 3;
  localparam int BASE_RATE_EDGES = BASE_WINDOW / WINDOW_DIVISOR;
  localparam int SYNC_STAGES = 3;
endpackage

// ---- insr_rate_counter.sv ----
// counts system clocks across one output-rate period of the sensor
`timescale 1ns/1ps
module insr_rate_counter #(
  parameter int COUNT_WIDTH = 24
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic oscPin,
  input wire logic enable,
  input wire logic [2:0] windowCode,
  output logic done,
  output logic [COUNT_WIDTH-1:0] periodCount
);
  logic [insr_pkg::SYNC_STAGES-1:0] oscSync;
  logic [15:0] edgeCount;
  logic [COUNT_WIDTH-1:0] clkCount;
  logic oscLevel;
  // a rising edge counts once the last two stages agree on it
  wire oscAgree = oscSync[1] == oscSync[2];
  wire oscEdge = oscAgree && oscSync[2] && !oscLevel;
  // one third of the window, in oscillations, doubles with each code
  wire [15:0] targetEdges =
    16'(insr_pkg::BASE_RATE_EDGES) << windowCode;
  wire lastEdge = oscEdge && (edgeCount == targetEdges - 16'h0001);
  wire [COUNT_WIDTH-1:0] next_clkCount =
    (&clkCount) ? clkCount : clkCount + 1'b1;

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      oscSync <= '0;
      oscLevel <= 1'b0;
      edgeCount <= 16'h0000;
      clkCount <= '0;
      done <= 1'b0;
      periodCount <= '0;
    end
    else if (ce)
    begin
      oscSync <= {oscSync[1:0], oscPin};
      if (oscAgree)
        oscLevel <= oscSync[2];
      done <= enable && lastEdge;
      if (!enable)
      begin
        edgeCount <= 16'h0000;
        clkCount <= '0;
      end
      else if (lastEdge)
      begin
        edgeCount <= 16'h0000;
        clkCount <= '0;
        periodCount <= next_clkCount;
      end
      else
      begin
        clkCount <= next_clkCount;
        if (oscEdge)
          edgeCount <= edgeCount + 16'h0001;
      end
    end
  end

  logic [15:0] doneEdges;
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      doneEdges <= 16'h0000;
    else if (ce && !enable)
      doneEdges <= 16'h0000;
    else if (ce && oscEdge)
      doneEdges <= lastEdge ? 16'h0000 : doneEdges + 16'h0001;
  end

  property p_rate_period;
    @(posedge clk_sys) disable iff (!reset_n)
    ce && enable && oscEdge && doneEdges == targetEdges - 16'h0001
      |=> done;
  endproperty
  a_rate_period: assert property (p_rate_period)
    else $error("period did not end after one third of the window");
endmodule

// ---- insr_host.sv ----
// host model issuing register reads and writes
`timescale 1ns/1ps
module insr_host (
  input wire logic clk_sys,
  output logic [7:0] regAddr,
  output logic regReadStart,
  output logic regWrite,
  output logic [7:0] regWriteData
);
  initial
  begin
    regAddr = 8'h00;
    regReadStart = 1'b0;
    regWrite = 1'b0;
    regWriteData = 8'h00;
  end
  // callers pass only listed range codes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regWriteData = d;
    regWrite = 1'b1;
    @(negedge clk_sys);
    regWrite = 1'b0;
    regWriteData = ~d;
  endtask
  // callers start result sets with the low proximity byte, except the hold test, which reads the high byte first
  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys);
    regAddr = a;
    regReadStart = 1'b1;
    @(negedge clk_sys);
    regReadStart = 1'b0;
    regAddr = ~a;
  endtask
endmodule

// ---- insr_readout_tb.sv ----
// self-checking bench for the result snapshot readout
`timescale 1ns/1ps
module insr_readout_tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic oscPin = 1'b0;
  logic [15:0] impedanceRaw = 16'h0000;
  logic impedanceBelowFloor = 1'b0;
  logic impedanceAboveCeiling = 1'b0;
  logic [7:0] regAddr, regWriteData, regReadData;
  logic regReadStart, regWrite, conversionActive;
  logic tookRead = 1'b0;
  logic [7:0] impedanceRangeFloor, impedanceRangeCeiling;
  logic [7:0] expQ[$];
  logic [15:0] v;
  int bad_count = 0;
  int checked = 0;
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end
  // sensor at one eighth of clk_sys: 512 clocks per base rate period, one third of the base window
  initial
  begin
    forever #400 oscPin = ~oscPin;
  end
  insr_host u_insr_host (.clk_sys(clk_sys), .regAddr(regAddr),
    .regReadStart(regReadStart), .regWrite(regWrite),
    .regWriteData(regWriteData));
  insr_readout u_insr_readout (.clk_sys(clk_sys), .reset_n(reset_n),
    .ce(ce), .regAddr(regAddr), .regReadStart(regReadStart),
    .regWrite(regWrite), .regWriteData(regWriteData),
    .regReadData(regReadData), .oscPin(oscPin),
    .impedanceRaw(impedanceRaw), .impedanceBelowFloor(impedanceBelowFloor),
    .impedanceAboveCeiling(impedanceAboveCeiling),
    .impedanceRangeFloor(impedanceRangeFloor),
    .impedanceRangeCeiling(impedanceRangeCeiling),
    .conversionActive(conversionActive));
  task automatic check(input string n, input logic [7:0] e,
    input logic [7:0] s);
    checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rx(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    u_insr_host.rd(a);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  always @(posedge clk_sys)
    tookRead <= regReadStart & ce;
  // read data lands on the taking edge and is checked at the next falling edge
  always @(negedge clk_sys)
  begin
    if (tookRead)
    begin
      if (expQ.size() == 0)
      begin
        bad_count++;
        $display("[ERR] read data expected none seen %h", regReadData);
      end
      else
        check("read data", expQ.pop_front(), regReadData);
    end
  end
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    bad_count++;
    tally_and_finish;
  end
  initial
  begin
    v = 16'($urandom(24411));
    repeat (8) @(negedge clk_sys);
    reset_n = 1'b1;
    rx(8'h02, 8'h14);
    rx(8'h01, 8'h00);
    rx(8'h30, 8'h00);
    check("floor out", 8'h14, impedanceRangeFloor);
    u_insr_host.wr(8'h02, 8'h3B);
    u_insr_host.wr(8'h01, 8'h12);
    ce = 1'b0;
    u_insr_host.wr(8'h01, 8'h11);
    ce = 1'b1;
    rx(8'h02, 8'h3B);
    check("ceiling out", 8'h12, impedanceRangeCeiling);
    $display("test range codes done");
    v = 16'($urandom);
    impedanceRaw = v;
    u_insr_host.wr(8'h24, 8'hAA);
    u_insr_host.wr(8'h0B, 8'h01);
    check("active out", 8'h01, {7'h00, conversionActive});
    cyc(1200);
    rx(8'h21, v[7:0]);
    rx(8'h22, v[15:8]);
    rx(8'h23, 8'h00);
    rx(8'h24, 8'h02);
    rx(8'h25, 8'h00);
    $display("test snapshot done");
    impedanceRaw = ~v;
    cyc(1200);
    rx(8'h22, v[15:8]);
    v = ~v;
    rx(8'h21, v[7:0]);
    rx(8'h22, v[15:8]);
    $display("test hold done");
    u_insr_host.wr(8'h04, 8'h01);
    cyc(3200);
    rx(8'h21, v[7:0]);
    rx(8'h24, 8'h04);
    rx(8'h25, 8'h00);
    $display("test window done");
    impedanceAboveCeiling = 1'b1;
    impedanceBelowFloor = 1'b1;
    cyc(2200);
    rx(8'h21, 8'hFF);
    rx(8'h22, 8'hFF);
    impedanceAboveCeiling = 1'b0;
    cyc(2200);
    rx(8'h21, 8'h00);
    rx(8'h22, 8'h00);
    $display("test clipping done");
    reset_n = 1'b0;
    cyc(2);
    reset_n = 1'b1;
    rx(8'h02, 8'h14);
    rx(8'h01, 8'h00);
    rx(8'h04, 8'h00);
    rx(8'h20, 8'h60);
    check("active out", 8'h00, {7'h00, conversionActive});
    $display("test reset done");
    cyc(2);
    tally_and_finish;
  end
endmodule
